// ===== bench/fault_response_manager_tb_top.sv
// Testbench for the fault-response manager
module fault_response_manager_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic                      clk = 0, reset = 1, feedbackLow = 0;
	logic                      regWrite = 0, pwmTick;
	fault_resp_pkg::faults_t   faults = '0;
	fault_resp_pkg::resp_cfg_t respCfg = '0;
	fault_resp_pkg::switch_t   pwmSwitch, switchDrive;
	logic [7:0]                temperature = 8'h32, regReadData;
	logic [7:0]                regAddr = 8'hD7, regWriteData = 8'h00;
	logic                      peakLimitEnable, outputValidFlag, alert;
	logic                      rampActive;
	int                        badCount = 0, nCompared = 0, n, k;
	always #12.5 clk = ~clk;
	pwm_stage_model stage (.clk(clk), .reset(reset), .pwmTick(pwmTick),
		.pwmSwitch(pwmSwitch));
	fault_response_manager dut (.clk(clk), .reset(reset), .faults(faults),
		.respCfg(respCfg), .pwmTick(pwmTick), .pwmSwitch(pwmSwitch),
		.feedbackLow(feedbackLow), .temperature(temperature),
		.overTempLimit(8'h64), .startupRampTime(20'h00004),
		.regWrite(regWrite), .regAddr(regAddr), .regWriteData(regWriteData),
		.regReadData(regReadData), .switchDrive(switchDrive),
		.peakLimitEnable(peakLimitEnable), .outputValidFlag(outputValidFlag),
		.alert(alert), .rampActive(rampActive));
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		nCompared++;
		if (g !== e)
		begin
			badCount++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : cyc
	task rst();
		@(posedge clk);
		reset <= 1'b1;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
	endtask : rst
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge clk);
		regAddr <= a;
		cyc(1);
		chk(nm, e, regReadData);
	endtask : rd
	task hit(input logic [6:0] f);
		@(posedge clk);
		faults <= f;
		@(posedge clk);
		faults <= '0;
		#1;
	endtask : hit
	task waitValid();
		n = 0;
		#1;
		while (outputValidFlag !== 1'b1 && n < 400)
		begin
			cyc(1);
			n++;
		end
		chk("validBack", 1, outputValidFlag);
	endtask : waitValid
	task endOfTest();
		$display("compared %0d mismatched %0d", nCompared, badCount);
		if (badCount == 0 && nCompared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : endOfTest
	initial
	begin
		repeat (20000) @(posedge clk);
		badCount++;
		endOfTest();
	end
	initial
	begin
		rst();
		cyc(1);
		chk("rampAfterReset", 1, rampActive);
		rd(8'hD7, 8'h00, "limitsReset");
		wr(8'hD7, 8'h80);
		rd(8'hD7, 8'h80, "limitsWrite");
		rd(8'h10, 8'h00, "unmapped");
		waitValid();
		chk("rampOver", 0, rampActive);
		@(posedge clk);
		respCfg <= {5{fault_resp_pkg::RESP_IGNORE}};
		hit(7'h7C);
		chk("ignoreSw", pwmSwitch, switchDrive);
		chk("ignoreValid", 1, outputValidFlag);
		chk("peakLimit", 1, peakLimitEnable);
		$display("test ignore done");
		@(posedge clk);
		respCfg <= {5{fault_resp_pkg::RESP_RESTART}};
		for (k = 0; k < 2; k++)
		begin
			hit(7'h20 >> k);
			chk("uvToSw", 0, switchDrive);
			chk("uvToValid", 0, outputValidFlag);
			chk("uvToAlert", 1, alert);
			waitValid();
			chk("retryWait", 1, n >= 28);
		end
		wr(8'hD7, 8'h00);
		hit(7'h40);
		cyc(5);
		chk("ovLowOn", 1, switchDrive);
		@(posedge clk);
		feedbackLow <= 1'b1;
		cyc(2);
		chk("ovLowOff", 0, switchDrive);
		@(posedge clk);
		feedbackLow <= 1'b0;
		waitValid();
		chk("ovRetry", 1, n >= 26);
		wr(8'hD7, 8'h80);
		hit(7'h40);
		cyc(5);
		chk("ovHoldSw", 1, switchDrive);
		waitValid();
		chk("ovHoldRetry", 1, n >= 28);
		$display("test restart done");
		@(posedge clk);
		respCfg.overVolt <= fault_resp_pkg::RESP_LATCH;
		hit(7'h40);
		cyc(60);
		chk("latchSw", 1, switchDrive);
		chk("latchValid", 0, outputValidFlag);
		$display("test latch done");
		rst();
		waitValid();
		@(posedge clk);
		respCfg.overCurrent <= fault_resp_pkg::RESP_LATCH;
		faults <= 7'h08;
		k = 0;
		while (k < 3)
		begin
			cyc(1);
			if (pwmTick)
				k++;
		end
		cyc(2);
		chk("ocOff", 0, switchDrive);
		@(posedge clk);
		faults <= '0;
		$display("test overcurrent done");
		rst();
		waitValid();
		@(posedge clk);
		respCfg.overTemp <= fault_resp_pkg::RESP_IGNORE;
		faults <= 7'h01;
		cyc(3);
		chk("bandgapOff", 0, switchDrive);
		@(posedge clk);
		faults <= '0;
		waitValid();
		@(posedge clk);
		respCfg.overTemp <= fault_resp_pkg::RESP_RESTART;
		temperature <= 8'h64;
		hit(7'h02);
		@(posedge clk);
		temperature <= 8'h51;
		cyc(60);
		chk("coolHold", 0, switchDrive);
		@(posedge clk);
		temperature <= 8'h4F;
		waitValid();
		$display("test thermal done");
		endOfTest();
	end
endmodule : fault_response_manager_tb_top

// ===== bench/pwm_stage_model.sv
// Switching-stage model: count pulse and normal switch drive
module pwm_stage_model
(
	input  wire logic               clk,
	input  wire logic               reset,
	output logic                    pwmTick,
	output fault_resp_pkg::switch_t pwmSwitch
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] phase = 4'h0;
	always @(posedge clk)
		phase <= reset ? 4'h0 : phase + 4'h1;
	assign pwmTick   = (phase == 4'hF);
	assign pwmSwitch = '{highOn: ~phase[3], lowOn: phase[3]};
endmodule : pwm_stage_model

// ===== inc/fault_resp_pkg.sv
// Package: fault response constants, types and register map
package fault_resp_pkg;
	// Response settings
	typedef enum logic [1:0]
	{
		RESP_LATCH   = 2'b00,
		RESP_RESTART = 2'b01,
		RESP_IGNORE  = 2'b10
	} resp_t;

	// Manager states
	typedef enum logic [2:0]
	{
		ST_RAMP    = 3'b000,
		ST_RUN     = 3'b001,
		ST_OCDELAY = 3'b010,
		ST_OFF     = 3'b011,
		ST_WAIT    = 3'b100,
		ST_COOL    = 3'b101,
		ST_LATCHED = 3'b110
	} state_t;

	// Fault detector inputs
	typedef struct packed
	{
		logic overVolt;
		logic underVolt;
		logic startTimeout;
		logic lowOverCurrent;
		logic highOverCurrent;
		logic overTemp;
		logic bandgapOverTemp;
	} faults_t;

	// Programmed responses
	typedef struct packed
	{
		resp_t overVolt;
		resp_t underVolt;
		resp_t startTimeout;
		resp_t overCurrent;
		resp_t overTemp;
	} resp_cfg_t;

	// Switch commands
	typedef struct packed
	{
		logic highOn;
		logic lowOn;
	} switch_t;

	localparam logic [7:0] PERCENT_OV_UV_LIMITS_ADDR = 8'hD7;
	localparam logic [7:0] PERCENT_OV_UV_LIMITS_RST  = 8'h00;
	localparam int         LOWSIDE_SELECT_BIT        = 7;
	localparam logic [2:0] RESTART_RAMP_MULT         = 3'h7;
	localparam logic [1:0] OC_EXTRA_COUNTS           = 2'h3;
	localparam int         COOL_HYST_DEGC            = 20;
	localparam logic [7:0] COOL_HYST                 = 8'(COOL_HYST_DEGC);
	localparam int         RAMP_W                    = 20;
endpackage : fault_resp_pkg

// ===== src/fault_response_manager.sv
// Fault-response manager: decides switch drive after converter faults
module fault_response_manager
(
	input  wire logic                      clk,
	input  wire logic                      reset,
	input  wire fault_resp_pkg::faults_t   faults,
	input  wire fault_resp_pkg::resp_cfg_t respCfg,
	input  wire logic                      pwmTick,
	input  wire fault_resp_pkg::switch_t   pwmSwitch,
	input  wire logic                      feedbackLow,
	input  wire logic [7:0]                temperature,
	input  wire logic [7:0]                overTempLimit,
	input  wire logic [fault_resp_pkg::RAMP_W-1:0] startupRampTime,
	input  wire logic                      regWrite,
	input  wire logic [7:0]                regAddr,
	input  wire logic [7:0]                regWriteData,
	output logic [7:0]                     regReadData,
	output fault_resp_pkg::switch_t        switchDrive,
	output logic                           peakLimitEnable,
	output logic                           outputValidFlag,
	output logic                           alert,
	output logic                           rampActive
);
	localparam int RW = fault_resp_pkg::RAMP_W;

	default clocking checkClk @(posedge clk);
	endclocking
	default disable iff (reset);

	fault_resp_pkg::state_t state;
	fault_resp_pkg::state_t next_state;
	logic [7:0]  percentOvUvLimits;
	logic [RW+2:0] waitCount;
	logic [RW-1:0] rampCount;
	logic [1:0]  ocCount;
	logic        ovShutdown;
	logic        ovLowOn;
	logic        restartMode;
	logic        coolIsBandgap;
	logic        alertFlag;
	logic        coolPending;

	// Register access
	wire addrHit = regAddr == fault_resp_pkg::PERCENT_OV_UV_LIMITS_ADDR;
	assign regReadData = addrHit ? percentOvUvLimits : 8'h00;
	wire lowsideSelect =
		percentOvUvLimits[fault_resp_pkg::LOWSIDE_SELECT_BIT];

	// Active faults per response; undervolt and timeout masked in ramp
	wire monitorRun = state == fault_resp_pkg::ST_RUN;
	wire ovAct = faults.overVolt &&
		respCfg.overVolt != fault_resp_pkg::RESP_IGNORE;
	wire uvAct = monitorRun && faults.underVolt &&
		respCfg.underVolt != fault_resp_pkg::RESP_IGNORE;
	wire toAct = monitorRun && faults.startTimeout &&
		respCfg.startTimeout != fault_resp_pkg::RESP_IGNORE;
	wire ocAct = (faults.lowOverCurrent || faults.highOverCurrent) &&
		respCfg.overCurrent != fault_resp_pkg::RESP_IGNORE;
	wire otAct = faults.overTemp &&
		respCfg.overTemp != fault_resp_pkg::RESP_IGNORE;
	wire bgAct = faults.bandgapOverTemp;
	wire operating = state == fault_resp_pkg::ST_RUN ||
		state == fault_resp_pkg::ST_RAMP;

	wire [RW+2:0] restartWait = RW'(startupRampTime) *
		(RW+3)'(fault_resp_pkg::RESTART_RAMP_MULT);
	// Widened sum: a hot reading must not wrap into a false cool-down
	wire coolDone = coolIsBandgap ? !faults.bandgapOverTemp :
		(9'(temperature) + 9'(fault_resp_pkg::COOL_HYST) <=
		9'(overTempLimit));
	wire ocThird = pwmTick &&
		ocCount == fault_resp_pkg::OC_EXTRA_COUNTS - 2'h1;
	// Release-mode low side delays the retry; held mode does not
	wire lowSideWait = ovShutdown && ovLowOn && !lowsideSelect;
	wire rampDone = rampCount >= startupRampTime;

	always_comb
	begin
		next_state = state;
		unique case (state)
			fault_resp_pkg::ST_RAMP, fault_resp_pkg::ST_RUN:
			begin
				if (bgAct || otAct)
					next_state = fault_resp_pkg::ST_OFF;
				else if (ovAct || uvAct || toAct)
					next_state = fault_resp_pkg::ST_OFF;
				else if (ocAct)
					next_state = fault_resp_pkg::ST_OCDELAY;
				else if (state == fault_resp_pkg::ST_RAMP && rampDone)
					next_state = fault_resp_pkg::ST_RUN;
			end
			fault_resp_pkg::ST_OCDELAY:
				if (ocThird)
					next_state = fault_resp_pkg::ST_OFF;
			fault_resp_pkg::ST_OFF:
				if (coolPending && restartMode)
					next_state = fault_resp_pkg::ST_COOL;
				else if (restartMode)
					next_state = fault_resp_pkg::ST_WAIT;
				else
					next_state = fault_resp_pkg::ST_LATCHED;
			fault_resp_pkg::ST_WAIT:
				if (waitCount >= restartWait && !lowSideWait)
					next_state = fault_resp_pkg::ST_RAMP;
			fault_resp_pkg::ST_COOL:
				if (coolDone)
					next_state = fault_resp_pkg::ST_RAMP;
			fault_resp_pkg::ST_LATCHED:
				next_state = fault_resp_pkg::ST_LATCHED;
			default:
				next_state = fault_resp_pkg::ST_LATCHED;
		endcase
	end

	// Cause capture on leaving normal operation
	wire enterOff = operating && next_state == fault_resp_pkg::ST_OFF;
	wire enterOc = operating && next_state == fault_resp_pkg::ST_OCDELAY;
	wire thermal = bgAct || otAct;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state <= fault_resp_pkg::ST_RAMP;
			percentOvUvLimits <= fault_resp_pkg::PERCENT_OV_UV_LIMITS_RST;
			waitCount <= '0;
			rampCount <= '0;
			ocCount <= 2'h0;
			ovShutdown <= 1'b0;
			ovLowOn <= 1'b0;
			restartMode <= 1'b0;
			coolIsBandgap <= 1'b0;
			coolPending <= 1'b0;
			alertFlag <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (regWrite && addrHit)
				percentOvUvLimits <= regWriteData;
			rampCount <= state == fault_resp_pkg::ST_RAMP ?
				rampCount + RW'(1) : '0;
			waitCount <= state == fault_resp_pkg::ST_WAIT ?
				waitCount + (RW+3)'(1) : '0;
			if (state == fault_resp_pkg::ST_OCDELAY && pwmTick)
				ocCount <= ocCount + 2'h1;
			else if (state != fault_resp_pkg::ST_OCDELAY)
				ocCount <= 2'h0;
			if (enterOff || enterOc)
			begin
				alertFlag <= 1'b1;
				ovShutdown <= !thermal && ovAct;
				ovLowOn <= !thermal && ovAct;
				coolIsBandgap <= bgAct;
				coolPending <= thermal;
				restartMode <= thermal ?
					(bgAct || respCfg.overTemp == fault_resp_pkg::RESP_RESTART) :
					ovAct ? respCfg.overVolt == fault_resp_pkg::RESP_RESTART :
					uvAct ? respCfg.underVolt == fault_resp_pkg::RESP_RESTART :
					toAct ? respCfg.startTimeout == fault_resp_pkg::RESP_RESTART :
					respCfg.overCurrent == fault_resp_pkg::RESP_RESTART;
			end
			else if (state == fault_resp_pkg::ST_OFF && thermal)
				coolIsBandgap <= coolIsBandgap || bgAct;
			// Low side released once feedback falls, unless held
			if (ovLowOn && !lowsideSelect && feedbackLow)
				ovLowOn <= 1'b0;
			if (next_state == fault_resp_pkg::ST_RAMP &&
				state != fault_resp_pkg::ST_RAMP)
			begin
				ovShutdown <= 1'b0;
				ovLowOn <= 1'b0;
			end
			if (state == fault_resp_pkg::ST_RUN &&
				next_state == fault_resp_pkg::ST_RUN)
				alertFlag <= 1'b0;
		end
	end

	// Switch drive selection
	wire faultOff = state == fault_resp_pkg::ST_OFF ||
		state == fault_resp_pkg::ST_WAIT ||
		state == fault_resp_pkg::ST_COOL ||
		state == fault_resp_pkg::ST_LATCHED;
	assign switchDrive.highOn = faultOff ? 1'b0 : pwmSwitch.highOn;
	assign switchDrive.lowOn = faultOff ?
		(ovShutdown && ovLowOn) : pwmSwitch.lowOn;
	assign peakLimitEnable = 1'b1;
	assign outputValidFlag = state == fault_resp_pkg::ST_RUN;
	assign alert = alertFlag;
	assign rampActive = state == fault_resp_pkg::ST_RAMP;

	// Overcurrent delay: counting phase, then expiry on the third count
	sequence ocCounting;
		state == fault_resp_pkg::ST_OCDELAY && !ocThird;
	endsequence
	sequence ocExpired;
		state == fault_resp_pkg::ST_OCDELAY && ocThird;
	endsequence

	a_ov_high_off: assert property (
		faultOff |-> !switchDrive.highOn)
		else $error("High side on during fault shutdown");
	a_ov_low_hold: assert property (
		(faultOff && ovShutdown && lowsideSelect && ovLowOn)
		|=> (!faultOff || switchDrive.lowOn || !ovShutdown))
		else $error("Low side dropped while held");
	a_restart_wait: assert property (
		(state == fault_resp_pkg::ST_WAIT && waitCount < restartWait)
		|=> state != fault_resp_pkg::ST_RAMP)
		else $error("Restart before seven ramp times");
	a_ignore_pwm: assert property (
		(operating && !ovAct && !uvAct && !toAct && !ocAct && !thermal)
		|=> (operating && switchDrive == pwmSwitch))
		else $error("Ignored fault disturbed PWM");
	a_peak_limit: assert property (
		peakLimitEnable)
		else $error("Peak limit disabled");
	a_uv_ramp: assert property (
		(state == fault_resp_pkg::ST_RAMP && !ovAct && !ocAct && !thermal
		&& !rampDone) |=> state == fault_resp_pkg::ST_RAMP)
		else $error("Fault acted during ramp");
	a_cool_hold: assert property (
		(state == fault_resp_pkg::ST_COOL && !coolDone)
		|=> state == fault_resp_pkg::ST_COOL)
		else $error("Restart before cooling");
	a_bg_trip: assert property (
		(operating && faults.bandgapOverTemp)
		|=> state == fault_resp_pkg::ST_OFF)
		else $error("Bandgap trip not acted on");
	a_oc_counts: assert property (
		ocCounting
		|=> (state == fault_resp_pkg::ST_OCDELAY && switchDrive == pwmSwitch))
		else $error("Overcurrent shut down early");
	a_oc_expire: assert property (
		ocExpired |=> state == fault_resp_pkg::ST_OFF)
		else $error("Overcurrent not shut down after three counts");
	a_valid_low: assert property (
		(faultOff || state == fault_resp_pkg::ST_OCDELAY)
		|-> !outputValidFlag)
		else $error("Valid flag high during fault");
endmodule : fault_response_manager
